// file: src/stc_pkg.sv
// constants and types shared by the sensor id/config/clear register block
// assumes a bus engine outside that decodes frames into register commands
package stc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_REVISION_INFO    = 8'h02;
  localparam logic [7:0] ADDR_MAKER_CODE_LOW   = 8'h03;
  localparam logic [7:0] ADDR_MAKER_CODE_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_HOST_SELECT_CODE = 8'h07;
  localparam logic [7:0] ADDR_DEVICE_CONFIG    = 8'h12;
  localparam logic [7:0] ADDR_TEMP_FLAG_CLEAR  = 8'h13;
  localparam logic [7:0] ADDR_CURRENT_TEMP_LOW = 8'h31;

  // ---------------------------------------------------------------
  // field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int REV_MAJOR_HI   = 5;
  localparam int REV_MAJOR_LO   = 4;
  localparam int REV_MINOR_HI   = 3;
  localparam int REV_MINOR_LO   = 1;
  localparam int HOST_SEL_HI    = 3;
  localparam int HOST_SEL_LO    = 1;
  localparam int CFG_PEC_BIT    = 7;
  localparam int CFG_PAR_BIT    = 6;
  localparam int CFG_PROTO_BIT  = 5;
  localparam int CFG_AUTO_BIT   = 4;
  localparam int CFG_BASE_HI    = 3;
  localparam int CFG_BASE_LO    = 2;
  localparam int CFG_BURST_BIT  = 1;
  localparam logic [7:0] HOST_SEL_RESET  = 8'h0E;
  localparam logic [7:0] HOST_SEL_MASK   = 8'h0E;
  localparam logic [7:0] CONFIG_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_WR_MASK  = 8'hDE;
  localparam logic [7:0] CONFIG_CHK_MASK = 8'hC0;
  localparam logic [7:0] CLEAR_MASK      = 8'h0F;
  localparam logic [1:0] BASE_CURRENT_LOW = 2'h0;
  localparam logic [2:0] BURST_SHORT      = 3'h2;
  localparam logic [2:0] BURST_LONG       = 3'h4;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ---------------------------------------------------------------
  // commands from the bus engine and carried words
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE       = 3'b000,
    CMD_WRITE      = 3'b001,
    CMD_SET_HOST   = 3'b010,
    CMD_RESET_ADDR = 3'b011,
    CMD_BUS_RESET  = 3'b100
  } stc_cmd_kind_type;

  typedef enum logic [1:0] {
    PUB_IDLE = 2'b00,
    PUB_SEND = 2'b01
  } stc_pub_state_type;

  typedef struct packed {
    stc_cmd_kind_type kind;
    logic [7:0]       addr;
    logic [7:0]       data;
  } stc_link_cmd_type;

  typedef struct packed {
    logic [7:0] host_sel;
    logic [7:0] cfg;
  } stc_reg_view_type;

endpackage

// file: src/stc_sync2.sv
// two-flop level synchroniser, any width of independent bits
// assumes each bit is a slow level or a toggle
`timescale 1ns/10ps
module stc_sync2 import stc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,  // destination clock
  input  wire logic             rst,  // sync reset, active high
  input  wire logic             en,   // clock enable
  input  wire logic [WIDTH-1:0] d,    // foreign-domain level
  output logic      [WIDTH-1:0] q     // synchronised level
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      q          <= '0;
    end else if (en) begin
      stage1_reg <= d;
      q          <= stage1_reg;
    end
  end
endmodule // stc_sync2

// file: src/stc_word_cross.sv
// toggle handshake carrying one word between two clock domains
// assumes both resets come from one source
`timescale 1ns/10ps
module stc_word_cross import stc_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             src_clk,    // sending clock
  input  wire logic             src_rst,    // sending reset
  input  wire logic             src_en,     // sending enable
  input  wire logic             src_valid,  // word offered
  output logic                  src_ready,  // crossing idle
  input  wire logic [WIDTH-1:0] src_data,   // word to send
  input  wire logic             dst_clk,    // receiving clock
  input  wire logic             dst_rst,    // receiving reset
  input  wire logic             dst_en,     // receiving enable
  output logic                  dst_valid,  // one-cycle arrival pulse
  output logic      [WIDTH-1:0] dst_data    // arrived word
);
  logic             req_reg;
  logic             ack_reg;
  logic [WIDTH-1:0] hold_reg;
  logic             req_at_dst;
  logic             ack_at_src;
  wire              take = dst_en && (req_at_dst != ack_reg);

  assign src_ready = (req_reg == ack_at_src);

  // hold word stays still until the ack returns
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req_reg  <= 1'h0;
      hold_reg <= '0;
    end else if (src_en && src_valid && src_ready) begin
      req_reg  <= ~req_reg;
      hold_reg <= src_data;
    end
  end

  stc_sync2 #(.WIDTH(1)) u_req_sync (
    .clk (dst_clk),
    .rst (dst_rst),
    .en  (dst_en),
    .d   (req_reg),
    .q   (req_at_dst)
  );

  stc_sync2 #(.WIDTH(1)) u_ack_sync (
    .clk (src_clk),
    .rst (src_rst),
    .en  (src_en),
    .d   (ack_reg),
    .q   (ack_at_src)
  );

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      ack_reg   <= 1'h0;
      dst_valid <= 1'h0;
      dst_data  <= '0;
    end else if (dst_en) begin
      dst_valid <= take;
      if (take) begin
        ack_reg  <= ~ack_reg;
        dst_data <= hold_reg;
      end
    end
  end
endmodule // stc_word_cross

// file: src/stc_sensor_id_config_clear_regs.sv
// identity, host-select, configuration and flag-clear registers
// assumes a bus engine on link_clk delivers decoded commands and read
// addresses; status flags and conversion logic sit outside on clk
`timescale 1ns/10ps
module stc_sensor_id_config_clear_regs import stc_pkg::*; #(
  parameter logic [3:0] LOCAL_TYPE_CODE = 4'hA,  // arbitrary value
  parameter logic [1:0] MAJOR_REV       = 2'h1,  // arbitrary value
  parameter logic [2:0] MINOR_REV       = 3'h2,  // arbitrary value
  parameter logic [7:0] MAKER_LOW       = 8'h5A, // arbitrary value
  parameter logic [7:0] MAKER_HIGH      = 8'hC3  // arbitrary value
) (
  input  wire logic             clk,                // core clock
  input  wire logic             rst,                // sync reset, active high
  input  wire logic             ce,                 // core clock enable
  input  wire logic             link_clk,           // bus-side clock
  input  wire logic             link_i3c_mode,      // 1 while bus runs i3c basic
  input  wire logic             link_cmd_valid,     // command offered
  output logic                  link_cmd_ready,     // command accepted when high
  input  wire stc_link_cmd_type link_cmd,           // decoded command
  input  wire logic [7:0]       link_rd_addr,       // register read address
  output logic      [7:0]       link_rd_data,       // read byte, one link cycle late
  output logic      [6:0]       target_addr,        // address the device answers
  output logic                  packet_check_on,    // packet error check enabled
  output logic                  parity_off,         // parity check disabled
  output logic                  bus_protocol_flag,  // 1 = i3c basic
  output logic                  auto_pointer_on,    // reads start at default pointer
  output logic      [7:0]       auto_pointer_addr,  // default pointer target
  output logic      [2:0]       auto_pointer_burst, // bytes per packet check burst
  output logic      [3:0]       temp_flag_clear     // pulses: crit low, crit high, low, high
);

  // ---------------------------------------------------------------
  // link-side reset
  // ---------------------------------------------------------------
  logic link_rst;

  // core reset brought into the link domain
  stc_sync2 #(.WIDTH(1)) u_link_rst_sync (
    .clk (link_clk),
    .rst (1'h0),
    .en  (1'h1),
    .d   (rst),
    .q   (link_rst)
  );

  // ---------------------------------------------------------------
  // command crossing, link to core
  // ---------------------------------------------------------------
  logic             cmd_valid;
  stc_link_cmd_type cmd;

  stc_word_cross #(.WIDTH($bits(stc_link_cmd_type))) u_cmd_cross (
    .src_clk   (link_clk),
    .src_rst   (link_rst),
    .src_en    (1'h1),
    .src_valid (link_cmd_valid),
    .src_ready (link_cmd_ready),
    .src_data  (link_cmd),
    .dst_clk   (clk),
    .dst_rst   (rst),
    .dst_en    (ce),
    .dst_valid (cmd_valid),
    .dst_data  (cmd)
  );

  // ---------------------------------------------------------------
  // protocol level, link to core
  // ---------------------------------------------------------------
  logic i3c_mode;

  stc_sync2 #(.WIDTH(1)) u_mode_sync (
    .clk (clk),
    .rst (rst),
    .en  (ce),
    .d   (link_i3c_mode),
    .q   (i3c_mode)
  );

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire is_write   = cmd_valid && (cmd.kind == CMD_WRITE);
  wire wr_config  = is_write && (cmd.addr == ADDR_DEVICE_CONFIG);
  wire wr_clear   = is_write && (cmd.addr == ADDR_TEMP_FLAG_CLEAR);
  wire addr_reset = cmd_valid && (cmd.kind == CMD_RESET_ADDR);
  wire bus_reset  = cmd_valid && (cmd.kind == CMD_BUS_RESET);
  // host-id command honoured only in i2c mode
  wire set_host   = cmd_valid && (cmd.kind == CMD_SET_HOST) && !i3c_mode;
  // reset-address restores host-id only in i3c mode
  wire host_back  = bus_reset || (addr_reset && i3c_mode);
  wire chk_back   = bus_reset || addr_reset;

  // ---------------------------------------------------------------
  // host-select register
  // ---------------------------------------------------------------
  logic [7:0] host_reg;
  logic [7:0] host_next;

  // plain writes to the host-select offset never reach this register
  assign host_next = host_back ? HOST_SEL_RESET :
                     set_host  ? (cmd.data & HOST_SEL_MASK) :
                                 host_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      host_reg <= HOST_SEL_RESET;
    end else if (ce) begin
      host_reg <= host_next;
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [7:0] config_wr;
  logic [7:0] config_view;

  // protocol bit and bit 0 are not writable
  assign config_wr = (config_reg & ~CONFIG_WR_MASK) |
                     (cmd.data & CONFIG_WR_MASK);

  // check bits fall back to reset values on address or bus reset
  assign config_next = chk_back  ? (config_reg & ~CONFIG_CHK_MASK) :
                       wr_config ? config_wr :
                                   config_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      config_reg <= CONFIG_RESET;
    end else if (ce) begin
      config_reg <= config_next;
    end
  end

  // readable image with the live protocol bit
  always_comb begin
    config_view                = config_reg;
    config_view[CFG_PROTO_BIT] = i3c_mode;
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  wire [1:0] base_code = config_reg[CFG_BASE_HI:CFG_BASE_LO];

  assign target_addr       = {LOCAL_TYPE_CODE,
                              host_reg[HOST_SEL_HI:HOST_SEL_LO]};
  assign packet_check_on   = config_reg[CFG_PEC_BIT];
  assign parity_off        = config_reg[CFG_PAR_BIT];
  assign bus_protocol_flag = i3c_mode;
  assign auto_pointer_on   = config_reg[CFG_AUTO_BIT];
  // reserved start codes are undefined; they fall back to code 00
  assign auto_pointer_addr = (base_code == BASE_CURRENT_LOW) ?
                             ADDR_CURRENT_TEMP_LOW :
                             ADDR_CURRENT_TEMP_LOW;
  assign auto_pointer_burst = config_reg[CFG_BURST_BIT] ?
                              BURST_LONG : BURST_SHORT;

  // ---------------------------------------------------------------
  // temperature flag clear pulses
  // ---------------------------------------------------------------
  logic [3:0] clear_reg;
  logic [7:0] clear_bits;

  // ones clear, zeros and reserved bits do nothing
  assign clear_bits = wr_clear ? (cmd.data & CLEAR_MASK) : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      clear_reg <= 4'h0;
    end else if (ce) begin
      clear_reg <= clear_bits[3:0];
    end
  end

  assign temp_flag_clear = clear_reg;

  // ---------------------------------------------------------------
  // publishing readable registers to the link domain
  // ---------------------------------------------------------------
  stc_reg_view_type  view_now;
  stc_reg_view_type  sent_reg;
  stc_pub_state_type pub_state;
  stc_pub_state_type pub_next;
  logic              pub_ready;
  wire               pub_valid  = (pub_state == PUB_SEND);
  wire               view_stale = (view_now != sent_reg);

  assign view_now.host_sel = host_reg & HOST_SEL_MASK;
  assign view_now.cfg      = config_view;

  always_comb begin
    case (pub_state)
      PUB_IDLE: begin
        pub_next = view_stale ? PUB_SEND : PUB_IDLE;
      end
      PUB_SEND: begin
        pub_next = pub_ready ? PUB_IDLE : PUB_SEND;
      end
      default: begin
        pub_next = PUB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pub_state         <= PUB_IDLE;
      sent_reg.host_sel <= HOST_SEL_RESET;
      sent_reg.cfg      <= CONFIG_RESET;
    end else if (ce) begin
      pub_state <= pub_next;
      if (pub_valid && pub_ready) begin
        sent_reg <= view_now;
      end
    end
  end

  // ---------------------------------------------------------------
  // view crossing, core to link
  // ---------------------------------------------------------------
  logic             view_arrive;
  stc_reg_view_type view_in;
  stc_reg_view_type link_view_reg;

  stc_word_cross #(.WIDTH($bits(stc_reg_view_type))) u_view_cross (
    .src_clk   (clk),
    .src_rst   (rst),
    .src_en    (ce),
    .src_valid (pub_valid),
    .src_ready (pub_ready),
    .src_data  (view_now),
    .dst_clk   (link_clk),
    .dst_rst   (link_rst),
    .dst_en    (1'h1),
    .dst_valid (view_arrive),
    .dst_data  (view_in)
  );

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_view_reg.host_sel <= HOST_SEL_RESET;
      link_view_reg.cfg      <= CONFIG_RESET;
    end else if (view_arrive) begin
      link_view_reg <= view_in;
    end
  end

  // ---------------------------------------------------------------
  // link-side read port
  // ---------------------------------------------------------------
  logic [7:0] rev_byte;
  logic [7:0] read_sel;

  always_comb begin
    rev_byte                            = 8'h00;
    rev_byte[REV_MAJOR_HI:REV_MAJOR_LO] = MAJOR_REV;
    rev_byte[REV_MINOR_HI:REV_MINOR_LO] = MINOR_REV;
  end

  // clear register and unmapped offsets read zero
  assign read_sel =
    (link_rd_addr == ADDR_REVISION_INFO)    ? rev_byte :
    (link_rd_addr == ADDR_MAKER_CODE_LOW)   ? MAKER_LOW :
    (link_rd_addr == ADDR_MAKER_CODE_HIGH)  ? MAKER_HIGH :
    (link_rd_addr == ADDR_HOST_SELECT_CODE) ? link_view_reg.host_sel :
    (link_rd_addr == ADDR_DEVICE_CONFIG)    ? link_view_reg.cfg :
                                              READ_UNMAPPED;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_rd_data <= READ_UNMAPPED;
    end else begin
      link_rd_data <= read_sel;
    end
  end

endmodule // stc_sensor_id_config_clear_regs

// file: tb/stc_regs_sva.sv
// assertions for the id/config/clear register block
// assumes a bind from the bench top; inputs mirror the block ports
`timescale 1ns/10ps
module stc_regs_sva import stc_pkg::*; #(
  parameter logic [3:0] LOCAL_TYPE_CODE = 4'hA,
  parameter logic [1:0] MAJOR_REV       = 2'h1,
  parameter logic [2:0] MINOR_REV       = 3'h2
) (
  input wire logic             clk,                // core clock
  input wire logic             rst,                // reset
  input wire logic             ce,                 // enable
  input wire logic             link_clk,           // link clock
  input wire logic             link_i3c_mode,      // mode
  input wire logic             link_cmd_valid,     // offer
  input wire logic             link_cmd_ready,     // accept
  input wire stc_link_cmd_type link_cmd,           // command
  input wire logic [7:0]       link_rd_addr,       // read offset
  input wire logic [7:0]       link_rd_data,       // read byte
  input wire logic [6:0]       target_addr,        // address
  input wire logic             packet_check_on,    // check on
  input wire logic             parity_off,         // parity off
  input wire logic             bus_protocol_flag,  // protocol
  input wire logic             auto_pointer_on,    // auto read
  input wire logic [7:0]       auto_pointer_addr,  // pointer
  input wire logic [2:0]       auto_pointer_burst, // burst
  input wire logic [3:0]       temp_flag_clear     // pulses
);
  // ----------------------------------------
  // last written values and command age
  // ----------------------------------------
  logic [7:0] cfg_last;
  logic [7:0] clr_last;
  logic [3:0] cmd_age;
  wire take      = link_cmd_valid && link_cmd_ready;
  wire wr        = take && link_cmd.kind == CMD_WRITE;
  wire take_cfg  = wr && link_cmd.addr == ADDR_DEVICE_CONFIG;
  wire take_clr  = wr && link_cmd.addr == ADDR_TEMP_FLAG_CLEAR;
  wire take_host = take && link_cmd.kind inside {CMD_SET_HOST, CMD_RESET_ADDR, CMD_BUS_RESET};
  always_ff @(posedge link_clk) begin
    if (take_cfg) cfg_last <= link_cmd.data;
    if (take_clr) clr_last <= link_cmd.data;
  end
  always_ff @(posedge link_clk) begin
    if (rst || take_host) cmd_age <= 4'h0;
    else if (cmd_age != 4'hF) cmd_age <= cmd_age + 4'h1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_reset_values: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> target_addr == {LOCAL_TYPE_CODE, 3'h7} && !packet_check_on && !parity_off
      && !auto_pointer_on && temp_flag_clear == 4'h0) else $error("reset values wrong");
  chk_fixed_fields: assert property (@(posedge clk) disable iff (rst)
    target_addr[6:3] == LOCAL_TYPE_CODE && auto_pointer_addr == ADDR_CURRENT_TEMP_LOW)
    else $error("fixed address field wrong");
  chk_host_by_cmd: assert property (@(posedge clk) disable iff (rst)
    $changed(target_addr) |-> cmd_age < 4'hA) else $error("host code changed without command");
  chk_cfg_follows: assert property (@(posedge link_clk) disable iff (rst)
    take_cfg |-> ##[2:8] (packet_check_on == cfg_last[7] && parity_off == cfg_last[6]
      && auto_pointer_on == cfg_last[4])) else $error("config pins do not follow write");
  chk_burst_follows: assert property (@(posedge link_clk) disable iff (rst)
    take_cfg |-> ##[2:8] auto_pointer_burst == (cfg_last[1] ? BURST_LONG : BURST_SHORT))
    else $error("burst length wrong");
  chk_proto_tracks: assert property (@(posedge clk) disable iff (rst)
    $changed(link_i3c_mode) |-> ##[1:5] bus_protocol_flag == link_i3c_mode)
    else $error("protocol flag stale");
  chk_clear_pulse: assert property (@(posedge clk) disable iff (rst)
    temp_flag_clear != 4'h0 |-> temp_flag_clear == clr_last[3:0] ##1 temp_flag_clear == 4'h0)
    else $error("clear pulse wrong");
  chk_clear_reads_zero: assert property (@(posedge link_clk) disable iff (rst)
    link_rd_addr == ADDR_TEMP_FLAG_CLEAR |=> link_rd_data == 8'h00)
    else $error("clear register reads nonzero");
  chk_revision_read: assert property (@(posedge link_clk) disable iff (rst)
    link_rd_addr == ADDR_REVISION_INFO |=> link_rd_data == {2'h0, MAJOR_REV, MINOR_REV, 1'b0})
    else $error("revision read wrong");
  cov_cfg: cover property (@(posedge link_clk) disable iff (rst) take_cfg);
  cov_clr: cover property (@(posedge clk) disable iff (rst) temp_flag_clear != 4'h0);
  cov_host: cover property (@(posedge clk) disable iff (rst) $changed(target_addr));
endmodule // stc_regs_sva

// file: tb/stc_host_model.sv
// bus engine model on the link side: one command per transaction
// assumes link_clk runs free; commands wait for ready both ways
`timescale 1ns/10ps
module stc_host_model import stc_pkg::*; (
  input  wire logic       link_clk,       // link clock
  input  wire logic       link_cmd_ready, // accept
  input  wire logic [7:0] link_rd_data,   // read byte
  output stc_link_cmd_type link_cmd,      // command
  output logic            link_cmd_valid, // offer
  output logic            link_i3c_mode,  // mode
  output logic [7:0]      link_rd_addr    // read offset
);
  initial begin
    link_cmd_valid = 1'b0;
    link_cmd = '0;
    link_i3c_mode = 1'b0;
    link_rd_addr = ADDR_TEMP_FLAG_CLEAR;
  end
  task automatic wait_ready();
    logic r;
    do begin
      @(negedge link_clk);
      r = link_cmd_ready;
      @(posedge link_clk);
    end while (!r);
  endtask
  // stop follows each write; nothing chained on
  task automatic send(input stc_cmd_kind_type k, input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk);
    link_cmd_valid <= 1'b1;
    link_cmd <= '{kind: k, addr: a, data: d};
    wait_ready();
    link_cmd_valid <= 1'b0;
    link_cmd <= stc_link_cmd_type'(~{k, a, d});
    wait_ready();
    repeat (12) @(posedge link_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge link_clk);
    link_rd_addr <= a;
    @(posedge link_clk);
    @(negedge link_clk);
    d = link_rd_data;
  endtask
  task automatic set_mode(input logic m);
    @(posedge link_clk);
    link_i3c_mode <= m;
    repeat (12) @(posedge link_clk);
  endtask
endmodule // stc_host_model

// file: tb/stc_sensor_id_config_clear_regs_bench.sv
// self-checking bench for the id/config/clear register block
// assumes the host model drives every link-side input except link_clk, which the bench makes
`timescale 1ns/10ps
module stc_sensor_id_config_clear_regs_bench import stc_pkg::*;;
  // arbitrary values
  localparam logic [3:0] LOCAL_CODE = 4'h9;
  localparam logic [1:0] MAJ        = 2'h2;
  localparam logic [2:0] MIN        = 3'h5;
  localparam logic [7:0] MK_LO      = 8'h3C;
  localparam logic [7:0] MK_HI      = 8'hA5;
  logic             clk = 1'b0;
  logic             link_clk = 1'b1;
  logic             rst, ce, seen_reset;
  logic             link_i3c_mode, link_cmd_valid, link_cmd_ready;
  stc_link_cmd_type link_cmd;
  logic [7:0]       link_rd_addr, link_rd_data, rd_val, auto_pointer_addr;
  logic [6:0]       target_addr;
  logic             packet_check_on, parity_off, bus_protocol_flag, auto_pointer_on;
  logic [2:0]       auto_pointer_burst;
  logic [3:0]       temp_flag_clear, seen_clear;
  wire  [7:0]       pin_view;
  int               errors, check_count;
  assign pin_view = {packet_check_on, parity_off, bus_protocol_flag, auto_pointer_on, 2'b00,
                     auto_pointer_burst == BURST_LONG, 1'b0};
  always #25 clk = ~clk;
  always #32 link_clk = ~link_clk;
  always @(posedge clk) begin
    if (seen_reset) seen_clear <= 4'h0;
    else seen_clear <= seen_clear | temp_flag_clear;
  end
  stc_sensor_id_config_clear_regs #(.LOCAL_TYPE_CODE(LOCAL_CODE), .MAJOR_REV(MAJ),
    .MINOR_REV(MIN), .MAKER_LOW(MK_LO), .MAKER_HIGH(MK_HI)) stc_sensor_id_config_clear_regs_inst (
    .clk, .rst, .ce, .link_clk, .link_i3c_mode, .link_cmd_valid, .link_cmd_ready, .link_cmd,
    .link_rd_addr, .link_rd_data, .target_addr, .packet_check_on, .parity_off,
    .bus_protocol_flag, .auto_pointer_on, .auto_pointer_addr, .auto_pointer_burst,
    .temp_flag_clear);
  stc_host_model stc_host_model_inst (.link_clk, .link_cmd_ready, .link_rd_data, .link_cmd,
    .link_cmd_valid, .link_i3c_mode, .link_rd_addr);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    stc_host_model_inst.rd(a, rd_val);
    check(rd_val, exp, $sformatf("read of %h", a));
  endtask
  task automatic cmd(input stc_cmd_kind_type k, input logic [7:0] a, input logic [7:0] d);
    stc_host_model_inst.send(k, a, d);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge link_clk);
    check({1'b0, target_addr}, {1'b0, LOCAL_CODE, 3'h7}, "target");
    check(pin_view, 8'h00, "config pins");
    check({5'h0, auto_pointer_burst}, {5'h0, BURST_SHORT}, "burst");
    rchk(ADDR_HOST_SELECT_CODE, 8'h0E);
    rchk(ADDR_DEVICE_CONFIG, 8'h00);
    $display("reset done, mismatches %0d", errors);
  endtask
  task automatic t_ident();
    for (int i = 0; i < 2; i++) begin
      rchk(ADDR_REVISION_INFO, {2'h0, MAJ, MIN, 1'b0});
      rchk(ADDR_MAKER_CODE_LOW, MK_LO);
      rchk(ADDR_MAKER_CODE_HIGH, MK_HI);
      for (int a = 2; a < 5; a++) cmd(CMD_WRITE, 8'(a), 8'hFF);
    end
    $display("identity done, mismatches %0d", errors);
  endtask
  task automatic t_host();
    cmd(CMD_WRITE, ADDR_HOST_SELECT_CODE, 8'h04);
    rchk(ADDR_HOST_SELECT_CODE, 8'h0E);
    cmd(CMD_SET_HOST, 8'h00, 8'hF5);
    rchk(ADDR_HOST_SELECT_CODE, 8'h04);
    check({1'b0, target_addr}, {1'b0, LOCAL_CODE, 3'h2}, "target");
    cmd(CMD_BUS_RESET, 8'h00, 8'h00);
    rchk(ADDR_HOST_SELECT_CODE, 8'h0E);
    cmd(CMD_SET_HOST, 8'h00, 8'h0A);
    stc_host_model_inst.set_mode(1'b1);
    check({7'h0, bus_protocol_flag}, 8'h01, "protocol");
    cmd(CMD_SET_HOST, 8'h00, 8'h06);
    rchk(ADDR_HOST_SELECT_CODE, 8'h0A);
    cmd(CMD_RESET_ADDR, 8'h00, 8'h00);
    rchk(ADDR_HOST_SELECT_CODE, 8'h0E);
    stc_host_model_inst.set_mode(1'b0);
    $display("host code done, mismatches %0d", errors);
  endtask
  task automatic t_config();
    stc_host_model_inst.set_mode(1'b1);
    cmd(CMD_WRITE, ADDR_DEVICE_CONFIG, 8'hD3); // burst written the same in i3c and i2c
    rchk(ADDR_DEVICE_CONFIG, 8'hF2);
    check(pin_view, 8'hF2, "config pins");
    check(auto_pointer_addr, ADDR_CURRENT_TEMP_LOW, "pointer");
    cmd(CMD_RESET_ADDR, 8'h00, 8'h00);
    rchk(ADDR_DEVICE_CONFIG, 8'h32);
    stc_host_model_inst.set_mode(1'b0);
    cmd(CMD_WRITE, ADDR_DEVICE_CONFIG, 8'h42); // burst written in i2c as in i3c
    rchk(ADDR_DEVICE_CONFIG, 8'h42);
    check(pin_view, 8'h42, "config pins");
    cmd(CMD_WRITE, ADDR_DEVICE_CONFIG, 8'h92);
    cmd(CMD_BUS_RESET, 8'h00, 8'h00);
    rchk(ADDR_DEVICE_CONFIG, 8'h12);
    $display("config done, mismatches %0d", errors);
  endtask
  task automatic t_clear();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) seen_reset <= 1'b1;
      @(posedge clk) seen_reset <= 1'b0;
      cmd(CMD_WRITE, ADDR_TEMP_FLAG_CLEAR, (i < 4) ? 8'(1 << i) : 8'hF0);
      check({4'h0, seen_clear}, (i < 4) ? 8'(1 << i) : 8'h00, "pulses");
    end
    rchk(ADDR_TEMP_FLAG_CLEAR, 8'h00);
    cmd(CMD_WRITE, 8'h50, 8'hFF);
    rchk(8'h50, 8'h00);
    rchk(ADDR_DEVICE_CONFIG, 8'h12);
    cmd(CMD_SET_HOST, 8'h00, 8'h02);
    $display("clear done, mismatches %0d", errors);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    seen_reset = 1'b0;
    errors = 0;
    check_count = 0;
    t_reset();
    t_ident();
    t_host();
    t_config();
    t_clear();
    t_reset();
    final_report();
  end
  initial begin
    #1_000_000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // stc_sensor_id_config_clear_regs_bench
bind stc_sensor_id_config_clear_regs stc_regs_sva #(.LOCAL_TYPE_CODE(LOCAL_TYPE_CODE),
  .MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV)) stc_regs_sva_inst (
  .clk, .rst, .ce, .link_clk, .link_i3c_mode, .link_cmd_valid, .link_cmd_ready, .link_cmd,
  .link_rd_addr, .link_rd_data, .target_addr, .packet_check_on, .parity_off,
  .bus_protocol_flag, .auto_pointer_on, .auto_pointer_addr, .auto_pointer_burst,
  .temp_flag_clear);
